// ==== vtac_codec.sv ====
// Purpose: tag-side air codec, pulse-position decode and Manchester encode
// Assumes: pause_i high while a reader pause is demodulated; carrier_i is the
//          carrier square wave, both asynchronous to ref_clk_i
// Notes:   air timing counted in carrier ticks
`timescale 1ns/1ps
module vtac_codec #(
  parameter int POWERUP_CYCLES = vtac_pkg::POWERUP_CYC,
  parameter int TURN_CYCLES    = vtac_pkg::TURN_CYC
) (
  input  wire logic                      ref_clk_i,
  input  wire logic                      sys_rst_i,
  input  wire logic                      field_on_i,
  input  wire logic                      carrier_i,
  input  wire logic                      pause_i,
  input  wire vtac_pkg::vtac_apb_req_type apb_i,
  output logic [31:0]                    prdata_o,
  output logic                           pready_o,
  output logic                           pslverr_o,
  output vtac_pkg::vtac_rx_type          rx_stream_o,
  output logic                           rx_ready_o,
  output logic                           tx_busy_o,
  output logic                           load_mod_o
);
  import vtac_pkg::*;

  typedef struct packed {
    logic [1:0]        car_s;
    logic [1:0]        pau_s;
    logic [1:0]        fld_s;
    logic              car_q;
    logic              pau_q;
    vtac_rx_state_type rx;
    logic              from_tx;
    logic [15:0]       wait_cnt;
    logic [16:0]       tk;
    logic              mode4;
    logic [1:0]        pair_n;
    logic [7:0]        shreg;
    logic              first;
    vtac_rx_type       out;
    logic              err;
    logic [7:0]        rx_cnt;
    logic [2:0]        ctrl;
    vtac_tx_state_type tx;
    logic [7:0]        hold;
    logic              hold_last;
    logic              hold_full;
    logic [7:0]        cur;
    logic              cur_last;
    logic [2:0]        bit_n;
    logic              half;
    vtac_seg_type      seg;
    logic [7:0]        left;
    logic [4:0]        ph;
    logic              load;
    logic              under;
    logic [31:0]       rdata;
  } vtac_state_type;

  vtac_state_type st;
  vtac_state_type next_st;

  ////////////////////////////////////////////////////////////////////////////
  // segment table at high rate; delimiters use the same bit shapes
  function automatic vtac_seg_type seg_of(input vtac_tx_state_type s, input logic b,
                                          input logic dual, input logic h);
    vtac_seg_type r;
    r = '{K_OFF, N_BIT_OFF};
    unique case (s)
      T_SOF:
        r = h ? '{K_LO, N_DLM_LO} : (dual ? '{K_HI, N_DLM_HI} : '{K_OFF, N_DLM_OFF});
      T_EOF:
        r = h ? (dual ? '{K_HI, N_DLM_HI} : '{K_OFF, N_DLM_OFF}) : '{K_LO, N_DLM_LO};
      default:
      begin
        if (dual)
          r = (b ^ h) ? '{K_HI, N_BIT_HI} : '{K_LO, N_BIT_LO};
        else
          r = (b ^ h) ? '{K_OFF, N_BIT_OFF} : '{K_LO, N_BIT_LO};
      end
    endcase
    return r;
  endfunction

  // pulse count for the selected rate
  function automatic logic [7:0] scale(input logic [4:0] c, input logic high, input logic fast);
    logic [7:0] s;
    s = high ? {3'h0, c} : {1'b0, c, 2'h0};
    return fast ? {1'b0, s[7:1]} : s;
  endfunction

  logic       car_tick;
  logic       pau_edge;
  logic       eff_dual;
  logic [16:0] p;
  logic [16:0] hs;
  logic [8:0]  nslots;
  logic [4:0]  per;
  logic        wr;
  logic        acc;
  logic        tx_pending;

  assign car_tick   = st.car_s[1] & ~st.car_q;
  assign pau_edge   = st.pau_s[1] & ~st.pau_q;
  assign eff_dual   = st.ctrl[CTRL_DUAL] & ~st.ctrl[CTRL_FAST];
  assign p          = st.tk - DATA_ORG;
  assign hs         = (p + ROUND_TK) >> 7;
  assign nslots     = st.mode4 ? 9'h004 : 9'h100;
  assign per        = (st.seg.kind == K_HI) ? DIV_HI : DIV_LO;
  assign acc        = apb_i.psel & apb_i.penable;
  assign tx_pending = (apb_i.paddr == ADDR_TXDATA) & apb_i.pwrite & st.hold_full;
  assign pready_o   = ~tx_pending;
  assign wr         = acc & apb_i.pwrite & pready_o;
  assign pslverr_o  = acc & ~((apb_i.paddr == ADDR_CTRL) | (apb_i.paddr == ADDR_STATUS) |
                              (apb_i.paddr == ADDR_TXDATA));
  assign prdata_o   = st.rdata;
  assign rx_stream_o = st.out;
  assign rx_ready_o  = (st.rx == R_IDLE);
  assign tx_busy_o   = (st.tx != T_IDLE);
  assign load_mod_o  = st.load;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_st         = st;
    next_st.car_s   = {st.car_s[0], carrier_i};
    next_st.pau_s   = {st.pau_s[0], pause_i};
    next_st.fld_s   = {st.fld_s[0], field_on_i};
    next_st.car_q   = st.car_s[1];
    next_st.pau_q   = st.pau_s[1];
    next_st.out.valid = 1'b0;
    next_st.out.sof   = 1'b0;
    next_st.out.eof   = 1'b0;
    next_st.out.err   = 1'b0;
    if (wr && apb_i.paddr == ADDR_STATUS)
    begin
      next_st.err   = st.err & ~apb_i.pwdata[ST_ERR];
      next_st.under = st.under & ~apb_i.pwdata[ST_UNDER];
    end
    if (car_tick && st.tk != 17'h1FFFF)
      next_st.tk = st.tk + 17'h00001;

    // receive path
    unique case (st.rx)
      R_OFF:
      begin
        next_st.wait_cnt = st.wait_cnt + 16'h0001;
        if (st.wait_cnt >= 16'(POWERUP_CYCLES - 1))
          next_st.rx = R_IDLE;
      end
      R_IDLE:
        if (pau_edge)
        begin
          next_st.rx = R_SOF;
          next_st.tk = '0;
        end
      R_SOF:
        if (pau_edge)
        begin
          next_st.tk     = '0;
          next_st.pair_n = '0;
          next_st.first  = 1'b1;
          next_st.rx_cnt = '0;
          if (hs[3:0] + 4'h2 == SOF_HS_QUAD || hs[3:0] + 4'h2 == SOF_HS_BYTE)
          begin
            next_st.rx      = R_DATA;
            next_st.mode4   = (hs[3:0] + 4'h2 == SOF_HS_QUAD);
            next_st.out.sof = 1'b1;
          end
          else
            next_st.rx = R_IDLE;
        end
        else if (st.tk > SOF_LIMIT)
          next_st.rx = R_IDLE;
      R_DATA:
      begin
        if (pau_edge)
        begin
          if (st.tk + ROUND_TK < DATA_ORG || hs[16:1] >= {7'h0, nslots})
          begin
            next_st.rx      = R_IDLE;
            next_st.err     = 1'b1;
            next_st.out.err = 1'b1;
          end
          else if (!hs[0])
          begin
            next_st.rx      = R_IDLE;
            next_st.out.eof = 1'b1;
            next_st.err     = next_st.err | (st.mode4 & (st.pair_n != 2'h0));
          end
          else
          begin
            // second-half pause carries the slot value
            next_st.tk = st.tk - ((hs >> 1) << 8) - SLOT;
            if (st.mode4)
            begin
              next_st.shreg  = {hs[2:1], st.shreg[7:2]};
              next_st.pair_n = st.pair_n + 2'h1;
            end
            if (!st.mode4 || st.pair_n == 2'h3)
            begin
              next_st.out.data  = st.mode4 ? {hs[2:1], st.shreg[7:2]} : hs[8:1];
              next_st.out.valid = 1'b1;
              next_st.rx_cnt    = st.rx_cnt + 8'h01;
              next_st.first     = 1'b0;
              if (st.first)
              begin
                next_st.ctrl[CTRL_DUAL] = st.mode4 ? st.shreg[2] : hs[1];
                next_st.ctrl[CTRL_HIGH] = st.mode4 ? st.shreg[3] : hs[2];
              end
            end
          end
        end
        else if (st.tk > DATA_ORG + ({8'h0, nslots} << 8) + HALF_SLOT)
        begin
          next_st.rx      = R_IDLE;
          next_st.err     = 1'b1;
          next_st.out.err = 1'b1;
        end
      end
      R_BUSY:
        if (st.tx == T_IDLE)
        begin
          next_st.wait_cnt = st.wait_cnt + 16'h0001;
          if (st.wait_cnt >= 16'(TURN_CYCLES - 1))
            next_st.rx = R_IDLE;
        end
      default:
        next_st.rx = R_OFF;
    endcase

    // transmit path; a frame starts on any clock, then advances only on carrier periods
    if (st.tx == T_IDLE)
    begin
      next_st.load = 1'b0;
      if (st.hold_full && st.rx == R_IDLE)
      begin
        next_st.tx        = T_SOF;
        next_st.rx        = R_BUSY;
        next_st.wait_cnt  = '0;
        next_st.cur       = st.hold;
        next_st.cur_last  = st.hold_last;
        next_st.hold_full = 1'b0;
        next_st.bit_n     = '0;
        next_st.half      = 1'b0;
        next_st.ph        = '0;
        next_st.seg       = seg_of(T_SOF, 1'b1, eff_dual, 1'b0);
        next_st.left      = scale(next_st.seg.cnt, st.ctrl[CTRL_HIGH], st.ctrl[CTRL_FAST]);
      end
    end
    else if (car_tick)
    begin
      // phase runs across segment changes, so subcarrier switches stay continuous
      next_st.ph   = (st.ph == per) ? 5'h00 : st.ph + 5'h01;
      next_st.load = (st.seg.kind != K_OFF) && (st.ph < {1'b0, per[4:1]} + 5'h01);
      if (st.ph == per)
      begin
        next_st.left = st.left - 8'h01;
        if (st.left == 8'h01)
        begin
          next_st.half = ~st.half;
          if (st.half)
          begin
            unique case (st.tx)
              T_SOF:    next_st.tx = T_SOFBIT;
              T_SOFBIT: next_st.tx = T_DATA;
              T_DATA:
              begin
                next_st.bit_n = st.bit_n + 3'h1;                        // data lsb first
                if (st.bit_n == 3'h7)
                begin
                  if (st.cur_last)
                    next_st.tx = T_EOFBIT;
                  else if (st.hold_full)
                  begin
                    next_st.cur       = st.hold;
                    next_st.cur_last  = st.hold_last;
                    next_st.hold_full = 1'b0;
                  end
                  else
                  begin
                    // starved source: close the frame cleanly rather than stall the air
                    next_st.tx    = T_EOFBIT;
                    next_st.under = 1'b1;
                  end
                end
              end
              T_EOFBIT: next_st.tx = T_EOF;
              T_EOF:    next_st.tx = T_IDLE;
              default:  next_st.tx = T_IDLE;
            endcase
          end
          next_st.seg  = seg_of(next_st.tx, (next_st.tx == T_SOFBIT) |
                                ((next_st.tx == T_DATA) & next_st.cur[next_st.bit_n]),
                                eff_dual, ~st.half);
          next_st.left = scale(next_st.seg.cnt, st.ctrl[CTRL_HIGH], st.ctrl[CTRL_FAST]);
        end
      end
    end

    // bus writes; status clears were applied first so hardware sets win
    if (wr && apb_i.paddr == ADDR_CTRL)
      next_st.ctrl = apb_i.pwdata[2:0];
    if (wr && apb_i.paddr == ADDR_TXDATA)
    begin
      next_st.hold      = apb_i.pwdata[7:0];
      next_st.hold_last = apb_i.pwdata[TX_LAST];
      next_st.hold_full = 1'b1;
    end
    if (apb_i.psel && !apb_i.penable)
      unique case (apb_i.paddr)
        ADDR_CTRL:   next_st.rdata = {29'h0, st.ctrl};
        ADDR_STATUS: next_st.rdata = {16'h0, st.rx_cnt, 2'h0, st.under, st.mode4, st.err,
                                      st.hold_full, (st.tx != T_IDLE), (st.rx == R_IDLE)};
        default:     next_st.rdata = '0;
      endcase

    // field loss forces the receiver back into power-up
    if (!st.fld_s[1])
    begin
      next_st.rx       = R_OFF;
      next_st.wait_cnt = '0;
      next_st.tx       = T_IDLE;
      next_st.load     = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      st      <= '0;
      st.rx   <= R_OFF;
      st.tx   <= T_IDLE;
      st.ctrl <= CTRL_RST;
    end
    else
      st <= next_st;
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  a_idle_no_load: assert property (st.tx == T_IDLE |=> !load_mod_o)
    else $error("load modulation outside a response frame");
  a_fast_single: assert property (st.ctrl[CTRL_FAST] && st.tx != T_IDLE |-> st.seg.kind != K_HI)
    else $error("upper subcarrier used with fast command");
  a_phase_wrap: assert property (st.tx != T_IDLE |-> st.ph <= per)
    else $error("subcarrier phase out of range");
  a_power_wait: assert property ($rose(rx_ready_o) && $past(st.rx) == R_OFF
                                 |-> $past(st.wait_cnt) == 16'(POWERUP_CYCLES - 1))
    else $error("receiver ready before power-up time");
  a_turn_wait: assert property ($rose(rx_ready_o) && $past(st.rx) == R_BUSY
                                |-> $past(st.wait_cnt) == 16'(TURN_CYCLES - 1))
    else $error("receiver ready before turnaround time");
  a_quad_pairs: assert property (st.out.valid && st.mode4 |-> st.pair_n == 2'h0)
    else $error("byte completed with partial pair count");
  a_sof_enters: assert property (st.out.sof |-> st.rx == R_DATA && !st.out.valid)
    else $error("start delimiter without data phase");
  a_eof_ends: assert property (st.out.eof |-> st.rx == R_IDLE && !st.out.valid)
    else $error("end delimiter did not close frame");
  a_tx_blocks_rx: assert property (st.tx != T_IDLE |-> st.rx inside {R_BUSY, R_OFF})
    else $error("receiver open during response");

  c_frame_quad:  cover property (st.out.eof && st.mode4);
  c_byte_256:    cover property (st.out.valid && !st.mode4);
  c_tx_dual:     cover property (st.tx == T_SOF && eff_dual);
  c_tx_underrun: cover property ($rose(st.under));
endmodule

// ==== vtac_pkg.sv ====
// Purpose: constants and types for the vicinity tag air codec
// Assumes: 100 MHz system clock, carrier seen as a sampled input
// Notes:   frame and slot timing is counted in carrier periods; power-up and turnaround in system clocks
package vtac_pkg;
  localparam int          CLK_NS        = 10;
  localparam int          POWERUP_NS    = 100000;   // 0.1 ms
  localparam int          TURN_NS       = 311500;   // 311.5 us
  localparam int          POWERUP_CYC   = (POWERUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int          TURN_CYC      = (TURN_NS + CLK_NS - 1) / CLK_NS;
  // receive timebase in carrier periods
  localparam logic [16:0] HALF_SLOT     = 17'h00080;  // 9.44 us
  localparam logic [16:0] SLOT          = 17'h00100;  // 18.88 us
  localparam logic [16:0] ROUND_TK      = 17'h00040;
  localparam logic [16:0] DATA_ORG      = 17'h00100;
  localparam logic [16:0] SOF_LIMIT     = 17'h00480;
  localparam logic [3:0]  SOF_HS_QUAD   = 4'h6;
  localparam logic [3:0]  SOF_HS_BYTE   = 4'h8;
  // transmit subcarrier dividers and high-rate pulse counts
  localparam logic [4:0]  DIV_LO        = 5'h1F;      // carrier/32 minus one
  localparam logic [4:0]  DIV_HI        = 5'h1B;      // carrier/28 minus one
  localparam logic [4:0]  N_BIT_LO      = 5'h08;
  localparam logic [4:0]  N_BIT_HI      = 5'h09;
  localparam logic [4:0]  N_BIT_OFF     = 5'h08;
  localparam logic [4:0]  N_DLM_LO      = 5'h18;
  localparam logic [4:0]  N_DLM_HI      = 5'h1B;
  localparam logic [4:0]  N_DLM_OFF     = 5'h18;
  // register map
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_STATUS   = 8'h04;
  localparam logic [7:0]  ADDR_TXDATA   = 8'h0C;
  localparam int          CTRL_FAST     = 0;
  localparam int          CTRL_DUAL     = 1;
  localparam int          CTRL_HIGH     = 2;
  localparam int          ST_ERR        = 3;
  localparam int          ST_UNDER      = 5;
  localparam int          TX_LAST       = 8;
  localparam logic [2:0]  CTRL_RST      = 3'h0;

  typedef enum logic [2:0] {R_OFF, R_IDLE, R_SOF, R_DATA, R_BUSY} vtac_rx_state_type;
  typedef enum logic [2:0] {T_IDLE, T_SOF, T_SOFBIT, T_DATA, T_EOFBIT, T_EOF} vtac_tx_state_type;
  typedef enum logic [1:0] {K_OFF, K_LO, K_HI} vtac_kind_type;

  typedef struct packed {
    vtac_kind_type kind;
    logic [4:0]    cnt;
  } vtac_seg_type;

  typedef struct packed {
    logic [7:0] data;
    logic       valid;
    logic       sof;
    logic       eof;
    logic       err;
  } vtac_rx_type;

  typedef struct packed {
    logic       psel;
    logic       penable;
    logic       pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } vtac_apb_req_type;
endpackage

// ==== vtac_reader_model.sv ====
// Purpose: behavioural reader on the far side of the air link
// Assumes: free-running carrier of 125 ns while the field is on
// Notes:   records the tick of every load switch rising edge while cap is set
`timescale 1ns/1ps
module vtac_reader_model (
  output logic      carrier_o,
  output logic      pause_o,
  input  wire logic load_mod_i
);
  logic ph;
  logic cap;
  int   tick;
  int   rec[$];
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    ph = 1'b0;
    pause_o = 1'b0;
    cap = 1'b0;
    tick = 0;
    #3.3;
    forever
    begin
      #62.5 ph = ~ph;
    end
  end
  assign carrier_o = ph;
  always @(posedge ph) tick <= tick + 1;
  always @(posedge load_mod_i) if (cap) rec.push_back(tick);
  ////////////////////////////////////////////////////////////////////////
  task automatic wait_ticks(input int n);
    repeat (n) @(posedge ph);
  endtask
  // depth is settled in the analog front end, so a pause looks alike either way
  task automatic pause_at(input int n);
    wait_ticks(n);
    pause_o = 1'b1;
    wait_ticks(32);
    pause_o = 1'b0;
  endtask
  // one-byte frame; slot origin tracked in carrier ticks
  task automatic send_frame(input logic quad, input logic [7:0] b);
    int v;
    pause_at(0);
    pause_at(quad ? 736 : 992);
    wait_ticks(224);
    for (int k = 0; k < (quad ? 4 : 1); k++)
    begin
      v = quad ? int'(b[2*k+:2]) : int'(b);
      pause_at(256 * v + 160);
      wait_ticks(64);
    end
    pause_at(32);
    wait_ticks(8);
  endtask
endmodule

// ==== vtac_codec_test.sv ====
// Purpose: self-checking bench for the tag air codec
// Assumes: short power-up and turnaround counts, reader model on the air side
// Notes:   response checked as rising-edge ticks of the load switch
`timescale 1ns/1ps
module vtac_codec_test;
  import vtac_pkg::*;
  localparam int    PU   = 20;
  localparam int    TURN = 20;
  localparam int    CEIL = 130000;
  logic             ref_clk;
  logic             sys_rst;
  logic             field_on;
  logic             carrier;
  logic             pause;
  vtac_apb_req_type apb;
  logic [31:0]      prdata;
  logic             pready;
  logic             pslverr;
  vtac_rx_type      rx_stream;
  logic             rx_ready;
  logic             tx_busy;
  logic             load_mod;
  int               n_errors = 0;
  int               compares = 0;
  int               cycles = 0;
  int               n_sof;
  int               n_eof;
  int               n_err;
  int               t_exp;
  int               exp_t[$];
  logic [7:0]       rxq[$];
  logic [31:0]      r;
  logic             e;
  ////////////////////////////////////////////////////////////////////////
  vtac_codec #(.POWERUP_CYCLES(PU), .TURN_CYCLES(TURN)) dut_u (
    .ref_clk_i(ref_clk), .sys_rst_i(sys_rst), .field_on_i(field_on), .carrier_i(carrier),
    .pause_i(pause), .apb_i(apb), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .rx_stream_o(rx_stream), .rx_ready_o(rx_ready), .tx_busy_o(tx_busy), .load_mod_o(load_mod));
  vtac_reader_model rdr_u (.carrier_o(carrier), .pause_o(pause), .load_mod_i(load_mod));
  initial
  begin
    ref_clk = 1'b0;
    forever
    begin
      #5 ref_clk = ~ref_clk;
    end
  end
  always @(posedge ref_clk)
  begin
    cycles++;
    if (rx_stream.valid === 1'b1) rxq.push_back(rx_stream.data);
    if (rx_stream.sof === 1'b1) n_sof++;
    if (rx_stream.eof === 1'b1) n_eof++;
    if (rx_stream.err === 1'b1) n_err++;
    if (cycles == CEIL)
    begin
      n_errors++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    compares++;
    if (got !== want)
    begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  // sync jitter may move an edge by one tick
  task automatic chk_near(input int got, input int want);
    compares++;
    if (got > want + 1 || got < want - 1)
    begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  task automatic wrap_up();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic apb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge ref_clk);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge ref_clk);
    apb.penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 1000);
    r = prdata;
    e = pslverr;
    if (n >= 1000) n_errors++;
    apb.psel <= 1'b0;
    apb.penable <= 1'b0;
  endtask
  // sel 0 watches rx_ready, 1 watches tx_busy
  task automatic wait_for(input int sel, input logic lvl, input int lim, output int n);
    n = 0;
    while (((sel == 0) ? rx_ready : tx_busy) !== lvl && n < lim)
    begin
      @(posedge ref_clk);
      n++;
    end
  endtask
  task automatic add(input int n, input int per);
    if (per == 0) t_exp += n;
    else repeat (n)
    begin
      exp_t.push_back(t_exp);
      t_exp += per;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_powerup();
    int n;
    wait_for(0, 1'b1, PU + 50, n);
    chk(n >= PU, 1);
    chk(n <= PU + 8, 1);
  endtask
  task automatic t_rx(input logic quad, input logic [7:0] b, input logic [2:0] ctl);
    apb_xfer(1'b1, ADDR_CTRL, 32'h6);
    rxq.delete();
    n_sof = 0;
    n_eof = 0;
    n_err = 0;
    rdr_u.send_frame(quad, b);
    chk(rxq.size(), 1);
    chk(rxq[0], b);
    chk(n_sof, 1);
    chk(n_eof, 1);
    chk(n_err, 0);
    apb_xfer(1'b0, ADDR_CTRL, 32'h0);
    chk(r[2:0], ctl);
    apb_xfer(1'b0, ADDR_STATUS, 32'h0);
    chk({r[15:8], r[4]}, {8'h01, quad});
  endtask
  task automatic t_unmapped();
    apb_xfer(1'b0, 8'h08, 32'h0);
    chk(e, 1'b1);
    chk(r, 32'h0);
  endtask
  // fast command with dual asked for: single subcarrier, doubled high rate
  task automatic t_tx(input logic [7:0] b);
    int n;
    apb_xfer(1'b1, ADDR_CTRL, 32'h7);
    exp_t.delete();
    t_exp = 0;
    add(12, 32);
    add(128, 0);
    add(4, 32);
    for (int i = 0; i < 8; i++)
    begin
      if (b[i])
      begin
        add(128, 0);
        add(4, 32);
      end
      else
      begin
        add(4, 32);
        add(128, 0);
      end
    end
    add(4, 32);
    add(128, 0);
    add(12, 32);
    rdr_u.rec.delete();
    rdr_u.cap = 1'b1;
    apb_xfer(1'b1, ADDR_TXDATA, {23'h0, 1'b1, b});
    wait_for(1, 1'b1, 50, n);
    chk(tx_busy, 1'b1);
    chk(rx_ready, 1'b0);
    wait_for(1, 1'b0, 70000, n);
    rdr_u.cap = 1'b0;
    wait_for(0, 1'b1, TURN + 20, n);
    chk(n >= TURN - 1, 1);
    chk(n <= TURN + 4, 1);
    chk(rdr_u.rec.size(), exp_t.size());
    foreach (exp_t[i]) chk_near(rdr_u.rec[i] - rdr_u.rec[0], exp_t[i]);
  endtask
  task automatic t_field();
    int n;
    field_on <= 1'b0;
    wait_for(0, 1'b0, 20, n);
    chk(n <= 8, 1);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    sys_rst = 1'b1;
    field_on = 1'b1;
    apb = '0;
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_powerup();
    t_rx(1'b1, 8'h02, 3'h4);
    t_rx(1'b0, 8'h01, 3'h2);
    t_unmapped();
    t_tx(8'hA5);
    t_field();
    wrap_up();
  end
endmodule
